/* File: design/pwa_pkg.sv */
// Constants shared by the audio PWM output unit: register map, fields, timing.
package pwa_pkg;
   // ------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_STATUS = 6'h00;
   localparam logic [5:0] IDX_EXTRA = 6'h08;
   localparam logic [5:0] IDX_CTRL = 6'h09;
   localparam logic [5:0] IDX_MID = 6'h0A;
   localparam logic [5:0] IDX_UPPER = 6'h0B;
   localparam logic [5:0] IDX_DRIVE = 6'h13;
   localparam logic [5:0] IDX_MASK = 6'h20;
   localparam int ADDR_W = 8;

   // ------------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------------
   localparam int STAT_REQ_BIT = 2;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_GIE_BIT = 1;
   localparam int DRV_MON_EN_BIT = 0;
   localparam int DRV_FLAG_BIT = 1;
   localparam int DRV_LOW_BIT = 2;
   localparam int DRV_UP_BIT = 3;
   localparam logic [1:0] DRIVE_RST = 2'h3;
   localparam logic [11:0] IRQ_VECTOR = 12'h008;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Timing: one PWM code per sample period.
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int SAMPLE_HZ = 32_000;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(CLK_HZ / SAMPLE_HZ - 1);
   localparam int RES_8 = 8;
   localparam int RES_10 = 10;
   localparam int RES_12 = 12;
endpackage

/* File: design/pwa_pwm_audio_output.sv */
// Audio PWM output unit with AXI4-Lite register access and interrupt.
`timescale 1ns/1ps

// What this block does
// - Resolution 8, 10 or 12 bits, fixed option.
// - Top sample bit is sign, one means negative.
// - One PWM code per fixed 32 kHz period.
// - 8-bit: nibbles form sample, width in clocks.
// - Each completed code sets the status request flag.
// - Written sample takes effect at code end, or at once while disabled.
// - Enable bit runs modulator; disabled pins drive low.
// - Halt clears enable and floats both pins.
// - Two drive bits choose 100/75/50/25 percent.
// - 10-bit word from upper, middle, extra bits 3..2.
// - 10-bit magnitude spans 0 to 511.
// - 12-bit word from upper, middle, all extra.
// - Accepted interrupt vectors to entry 0x008.
module pwa_pwm_audio_output #(
   parameter int RESOLUTION = pwa_pkg::RES_8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [pwa_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [pwa_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic supply_low_pin,
   output logic speaker_out_positive_o,
   output logic speaker_out_positive_oe,
   output logic speaker_out_negative_o,
   output logic speaker_out_negative_oe,
   output logic drive_strength_upper,
   output logic drive_strength_lower,
   output logic supply_monitor_enable,
   output logic irq,
   output logic [11:0] irq_vector
);
   import pwa_pkg::*;

   // ------------------------------------------------------------------
   // Sample word assembly.
   // ------------------------------------------------------------------
   // Returns {sign, magnitude}; the magnitude is zero-extended to 11 bits.
   function automatic logic [11:0] pwa_word(input logic [3:0] up, input logic [3:0] mid,
                                            input logic [3:0] ext, input int res);
      case (res)
         RES_12: return {up[3], up[2:0], mid, ext};
         RES_10: return {up[3], 2'h0, up[2:0], mid, ext[3:2]};
         default: return {up[3], 4'h0, up[2:0], mid};
      endcase
   endfunction

   // Option pins of the resolution; fixed at build time, not by software.
   localparam bit ten_bit_option = (RESOLUTION == RES_10);
   localparam bit twelve_bit_option = (RESOLUTION == RES_12);
   localparam int RES_SEL = twelve_bit_option ? RES_12 : (ten_bit_option ? RES_10 : RES_8);

   logic [3:0] sample_extra_low_bits_reg, sample_middle_nibble_reg, sample_upper_nibble_reg;
   logic modulator_enable_reg, global_irq_enable_reg, sample_request_flag_reg, mask_reg;
   logic drive_upper_reg, drive_lower_reg, monitor_en_reg, halted_reg, act_sign_reg;
   logic supply_meta_reg, supply_sync_reg, aw_got_reg, w_got_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [10:0] act_mag_reg;
   logic [5:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [11:0] buf_word;
   logic end_code, do_write, ar_take, rd_status, wr_hit;
   logic aw_got_next, w_got_next, bvalid_next, pulse_on;

   assign buf_word = pwa_word(sample_upper_nibble_reg, sample_middle_nibble_reg,
                              sample_extra_low_bits_reg, RES_SEL);
   assign end_code = (cnt_reg == PERIOD_LAST);
   assign do_write = aw_got_reg && w_got_reg && !bvalid;
   assign ar_take = arvalid && arready;
   assign rd_status = ar_take && (araddr == {IDX_STATUS, 2'h0});
   assign pulse_on = ({1'b0, act_mag_reg} > cnt_reg);

   // ------------------------------------------------------------------
   // AXI4-Lite write channel.
   // ------------------------------------------------------------------
   // Address and data may arrive in either order; the write happens once both are held.
   always_comb begin
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      bvalid_next = bvalid;
      if (awvalid && awready) begin
         aw_got_next = 1'b1;
      end
      if (wvalid && wready) begin
         w_got_next = 1'b1;
      end
      if (do_write) begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
      end else if (bvalid && bready) begin
         bvalid_next = 1'b0;
      end
   end

   // Ready is held low while a write waits for its response, one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bresp <= RESP_OKAY;
         waddr_reg <= 6'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         bvalid <= bvalid_next;
         awready <= !aw_got_next && !bvalid_next;
         wready <= !w_got_next && !bvalid_next;
         if (awvalid && awready) begin
            waddr_reg <= awaddr[ADDR_W-1:2];
         end
         if (wvalid && wready) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (do_write) begin
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign wr_hit = (waddr_reg == IDX_STATUS) || (waddr_reg == IDX_EXTRA) ||
                   (waddr_reg == IDX_CTRL) || (waddr_reg == IDX_MID) ||
                   (waddr_reg == IDX_UPPER) || (waddr_reg == IDX_DRIVE) ||
                   (waddr_reg == IDX_MASK);

   // ------------------------------------------------------------------
   // Register file.
   // ------------------------------------------------------------------
   // Sample buffer registers; the active stage copies them at code end and on every cycle while disabled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_extra_low_bits_reg <= 4'h0;
         sample_middle_nibble_reg <= 4'h0;
         sample_upper_nibble_reg <= 4'h0;
      end else if (do_write && wstrb_reg[0]) begin
         case (waddr_reg)
            IDX_EXTRA: sample_extra_low_bits_reg <= wdata_reg[3:0];
            IDX_MID: sample_middle_nibble_reg <= wdata_reg[3:0];
            IDX_UPPER: sample_upper_nibble_reg <= wdata_reg[3:0];
            default: ;
         endcase
      end
   end

   // Control, mask and drive bits; halt overrides a same-cycle enable write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulator_enable_reg <= 1'b0;
         global_irq_enable_reg <= 1'b0;
         mask_reg <= 1'b0;
         {drive_upper_reg, drive_lower_reg} <= DRIVE_RST;
         monitor_en_reg <= 1'b0;
      end else begin
         if (do_write && wstrb_reg[0]) begin
            case (waddr_reg)
               IDX_CTRL: begin
                  modulator_enable_reg <= wdata_reg[CTRL_EN_BIT];
                  global_irq_enable_reg <= wdata_reg[CTRL_GIE_BIT];
               end
               IDX_MASK: mask_reg <= wdata_reg[STAT_REQ_BIT];
               IDX_DRIVE: begin
                  drive_upper_reg <= wdata_reg[DRV_UP_BIT];
                  drive_lower_reg <= wdata_reg[DRV_LOW_BIT];
                  monitor_en_reg <= wdata_reg[DRV_MON_EN_BIT];
               end
               default: ;
            endcase
         end
         if (halt_req) begin
            modulator_enable_reg <= 1'b0;
         end
      end
   end

   // Halt state floats the speaker pins until the core wakes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halted_reg <= 1'b0;
      end else if (halt_req) begin
         halted_reg <= 1'b1;
      end else if (wake_req) begin
         halted_reg <= 1'b0;
      end
   end

   // Sticky request flag; a status read clears it, but a new code end wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_request_flag_reg <= 1'b0;
      end else begin
         sample_request_flag_reg <= (end_code && modulator_enable_reg) ||
                                    (sample_request_flag_reg && !rd_status);
      end
   end

   // The supply comparator is asynchronous to aclk, so it is synchronised first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         supply_meta_reg <= 1'b0;
         supply_sync_reg <= 1'b0;
      end else begin
         supply_meta_reg <= supply_low_pin;
         supply_sync_reg <= supply_meta_reg;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel.
   // ------------------------------------------------------------------
   // Data answers one cycle after the address is taken; write-only samples read zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         case (araddr[ADDR_W-1:2])
            IDX_STATUS: rdata[STAT_REQ_BIT] <= sample_request_flag_reg;
            IDX_CTRL: begin
               rdata[CTRL_EN_BIT] <= modulator_enable_reg;
               rdata[CTRL_GIE_BIT] <= global_irq_enable_reg;
            end
            IDX_MASK: rdata[STAT_REQ_BIT] <= mask_reg;
            IDX_DRIVE: begin
               rdata[DRV_UP_BIT] <= drive_upper_reg;
               rdata[DRV_LOW_BIT] <= drive_lower_reg;
               rdata[DRV_FLAG_BIT] <= supply_sync_reg;
               rdata[DRV_MON_EN_BIT] <= monitor_en_reg;
            end
            IDX_EXTRA, IDX_MID, IDX_UPPER: ;
            default: rresp <= RESP_SLVERR;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Modulator.
   // ------------------------------------------------------------------
   // Period counter; it rests at zero while disabled so enabling starts a fresh code.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (!modulator_enable_reg || end_code) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Active stage tracks the buffer while idle so the first code uses preloaded data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_sign_reg <= 1'b0;
         act_mag_reg <= 11'h000;
      end else if (!modulator_enable_reg || end_code) begin
         act_sign_reg <= buf_word[11];
         act_mag_reg <= buf_word[10:0];
      end
   end

   // Pin drivers; a magnitude above the period simply holds the pin on all code.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speaker_out_positive_o <= 1'b0;
         speaker_out_negative_o <= 1'b0;
         speaker_out_positive_oe <= 1'b1;
         speaker_out_negative_oe <= 1'b1;
      end else begin
         speaker_out_positive_oe <= !halted_reg;
         speaker_out_negative_oe <= !halted_reg;
         if (!modulator_enable_reg || halted_reg) begin
            speaker_out_positive_o <= 1'b0;
            speaker_out_negative_o <= 1'b0;
         end else begin
            speaker_out_positive_o <= pulse_on && !act_sign_reg;
            speaker_out_negative_o <= pulse_on && act_sign_reg;
         end
      end
   end

   // Static outputs and the level interrupt with its entry vector.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_strength_upper <= 1'b1;
         drive_strength_lower <= 1'b1;
         supply_monitor_enable <= 1'b0;
         irq <= 1'b0;
         irq_vector <= 12'h000;
      end else begin
         drive_strength_upper <= drive_upper_reg;
         drive_strength_lower <= drive_lower_reg;
         supply_monitor_enable <= monitor_en_reg;
         irq <= sample_request_flag_reg && mask_reg && global_irq_enable_reg;
         irq_vector <= (sample_request_flag_reg && mask_reg && global_irq_enable_reg) ?
                       IRQ_VECTOR : 12'h000;
      end
   end

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   property p_idle_low;
      @(posedge aclk) disable iff (!aresetn)
      (!modulator_enable_reg && !halted_reg) |=>
         (!speaker_out_positive_o && !speaker_out_negative_o &&
          speaker_out_positive_oe && speaker_out_negative_oe);
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("Disabled pins not low.");
   property p_halt_float;
      @(posedge aclk) disable iff (!aresetn)
      halt_req && !wake_req |=> !modulator_enable_reg ##1
         (!speaker_out_positive_oe && !speaker_out_negative_oe);
   endproperty
   a_halt_float: assert property (p_halt_float) else $error("Halt did not float pins.");
   property p_flag_set;
      @(posedge aclk) disable iff (!aresetn)
      (end_code && modulator_enable_reg) |=> sample_request_flag_reg;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("Code end did not set flag.");
   property p_load_end;
      @(posedge aclk) disable iff (!aresetn)
      (modulator_enable_reg && !end_code) |=> $stable(act_mag_reg) && $stable(act_sign_reg);
   endproperty
   a_load_end: assert property (p_load_end) else $error("Active sample changed mid code.");
   property p_count;
      @(posedge aclk) disable iff (!aresetn)
      (modulator_enable_reg && !end_code) ##1 modulator_enable_reg |->
         cnt_reg == $past(cnt_reg) + CNT_W'(1);
   endproperty
   a_count: assert property (p_count) else $error("Period counter skipped.");
   property p_one_pin;
      @(posedge aclk) disable iff (!aresetn)
      (modulator_enable_reg && !halted_reg && act_sign_reg) |=> !speaker_out_positive_o;
   endproperty
   a_one_pin: assert property (p_one_pin) else $error("Wrong pin pulsed.");
   property p_width;
      @(posedge aclk) disable iff (!aresetn)
      (modulator_enable_reg && !halted_reg && pulse_on && !act_sign_reg) |=>
         speaker_out_positive_o;
   endproperty
   a_width: assert property (p_width) else $error("Pulse shorter than magnitude.");
   property p_vector;
      @(posedge aclk) disable iff (!aresetn)
      irq |-> irq_vector == IRQ_VECTOR;
   endproperty
   a_vector: assert property (p_vector) else $error("Interrupt vector wrong.");
   // A drive write reaches the pins two edges later, bit for bit as software wrote it.
   property p_drive;
      @(posedge aclk) disable iff (!aresetn)
      (do_write && wstrb_reg[0] && waddr_reg == IDX_DRIVE) |-> ##2
         drive_strength_upper == $past(wdata_reg[DRV_UP_BIT], 2) &&
         drive_strength_lower == $past(wdata_reg[DRV_LOW_BIT], 2);
   endproperty
   a_drive: assert property (p_drive) else $error("Drive bits not passed on.");
endmodule

/* File: testbench/pwa_speaker_model.sv */
// Behavioural loudspeaker load seen across the two complementary speaker pins.
`timescale 1ns/1ps
module pwa_speaker_model (
   input wire logic aclk,
   input wire logic pos_o,
   input wire logic pos_oe,
   input wire logic neg_o,
   input wire logic neg_oe,
   output logic pos_lvl,
   output logic neg_lvl
);
   logic float_pat;
   // A coil has no pull, so a released pin shows a level that changes every cycle.
   always @(posedge aclk) begin
      float_pat <= ~float_pat;
   end
   initial float_pat = 1'b0;
   // Each terminal follows its pin while driven, else the wandering pattern.
   assign pos_lvl = pos_oe ? pos_o : float_pat;
   assign neg_lvl = neg_oe ? neg_o : ~float_pat;
endmodule

/* File: testbench/tb_pwm_audio_output.sv */
// Self-checking bench for the audio PWM output unit in all three resolutions.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_pwm_audio_output;
   import pwa_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, halt_req = 0, wake_req = 0, supply_low_pin = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, irq, supply_monitor_enable;
   logic speaker_out_positive_o, speaker_out_positive_oe;
   logic speaker_out_negative_o, speaker_out_negative_oe;
   logic drive_strength_upper, drive_strength_lower, p_lvl, n_lvl;
   logic [11:0] irq_vector;
   int errors = 0, check_count = 0;

   pwa_pwm_audio_output dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
      .rready, .rdata, .rresp, .halt_req, .wake_req, .supply_low_pin,
      .speaker_out_positive_o, .speaker_out_positive_oe, .speaker_out_negative_o,
      .speaker_out_negative_oe, .drive_strength_upper, .drive_strength_lower,
      .supply_monitor_enable, .irq, .irq_vector);
   pwa_speaker_model spk (.aclk, .pos_o(speaker_out_positive_o),
      .pos_oe(speaker_out_positive_oe), .neg_o(speaker_out_negative_o),
      .neg_oe(speaker_out_negative_oe), .pos_lvl(p_lvl), .neg_lvl(n_lvl));
   // The wider builds share the bus and follow it cycle for cycle; only their pins are watched.
   logic p10, n10, p12, n12;
   pwa_pwm_audio_output #(.RESOLUTION(RES_10)) dut10 (.aclk, .aresetn, .awvalid,
      .awready(), .awaddr, .wvalid, .wready(), .wdata, .wstrb, .bvalid(), .bready, .bresp(),
      .arvalid, .arready(), .araddr, .rvalid(), .rready, .rdata(), .rresp(), .halt_req,
      .wake_req, .supply_low_pin, .speaker_out_positive_o(p10), .speaker_out_positive_oe(),
      .speaker_out_negative_o(n10), .speaker_out_negative_oe(), .drive_strength_upper(),
      .drive_strength_lower(), .supply_monitor_enable(), .irq(), .irq_vector());
   pwa_pwm_audio_output #(.RESOLUTION(RES_12)) dut12 (.aclk, .aresetn, .awvalid,
      .awready(), .awaddr, .wvalid, .wready(), .wdata, .wstrb, .bvalid(), .bready, .bresp(),
      .arvalid, .arready(), .araddr, .rvalid(), .rready, .rdata(), .rresp(), .halt_req,
      .wake_req, .supply_low_pin, .speaker_out_positive_o(p12), .speaker_out_positive_oe(),
      .speaker_out_negative_o(n12), .speaker_out_negative_oe(), .drive_strength_upper(),
      .drive_strength_lower(), .supply_monitor_enable(), .irq(), .irq_vector());

   always #12.5 aclk = ~aclk;

   // ------------------------------------------------------------------
   // Bus tasks; every wait is bounded so a dead handshake ends the run.
   // ------------------------------------------------------------------
   task automatic print_verdict();
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tmo();
      errors++;
      print_verdict();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid && bready) begin
            r = bresp; bready <= 0; break;
         end
      end
      if (n == 100) tmo();
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid && rready) begin
            d = rdata; r = rresp; rready <= 0; break;
         end
      end
      if (n == 100) tmo();
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      logic [1:0] r;
      axw({i, 2'b00}, d, r);
   endtask
   task automatic rd(input logic [5:0] i, output logic [31:0] d);
      logic [1:0] r;
      axr({i, 2'b00}, d, r);
   endtask
   // Measures one whole code on the chosen pin: pulse length, period, other pin.
   task automatic meas(input bit ng, input int ehi, input int e10, input int e12);
      int n, hi, per, oth, h10, h12;
      logic prev;
      hi = 1; per = 1; oth = 0; h10 = 1; h12 = 1;
      for (n = 0; n < 3000; n++) begin
         @(posedge aclk);
         if ((ng ? n_lvl : p_lvl) === 1'b0) break;
      end
      if (n == 3000) tmo();
      for (n = 0; n < 3000; n++) begin
         @(posedge aclk);
         if ((ng ? n_lvl : p_lvl) === 1'b1) break;
      end
      if (n == 3000) tmo();
      prev = 1;
      for (n = 0; n < 3000; n++) begin
         @(posedge aclk);
         if ((ng ? n_lvl : p_lvl) === 1'b1 && !prev) break;
         prev = ng ? n_lvl : p_lvl;
         hi += (prev === 1'b1);
         oth += ((ng ? p_lvl : n_lvl) !== 1'b0);
         h10 += ((ng ? n10 : p10) === 1'b1);
         h12 += ((ng ? n12 : p12) === 1'b1);
         per++;
      end
      if (n == 3000) tmo();
      `CHK(hi, ehi)
      `CHK(h10, e10)
      `CHK(h12, e12)
      `CHK(per, 1250)
      `CHK(oth, 0)
   endtask

   // ------------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------------
   task automatic t_reset_map();
      logic [31:0] d;
      logic [1:0] r;
      `CHK({speaker_out_positive_o, speaker_out_negative_o}, 2'b00)
      `CHK({speaker_out_positive_oe, speaker_out_negative_oe}, 2'b11)
      rd(IDX_DRIVE, d);
      `CHK(d, 32'h0000000C)
      rd(IDX_CTRL, d);
      `CHK(d, 32'h00000000)
      axr(8'h40, d, r);
      `CHK(r, RESP_SLVERR)
      axw(8'h44, 32'h0000000F, r);
      `CHK(r, RESP_SLVERR)
   endtask
   task automatic t_drive();
      logic [31:0] d;
      for (int v = 0; v < 4; v++) begin
         wr(IDX_DRIVE, 32'(v) << 2);
         @(posedge aclk);
         `CHK({drive_strength_upper, drive_strength_lower}, 2'(v))
         rd(IDX_DRIVE, d);
         `CHK(d[3:2], 2'(v))
      end
      wr(IDX_DRIVE, 32'h0000000C);
   endtask
   // Pulse width, period, sign and mid-code reload.
   task automatic t_pwm();
      wr(IDX_EXTRA, 32'h0000000D);
      wr(IDX_MID, 32'h00000005);
      wr(IDX_UPPER, 32'h00000002);
      wr(IDX_CTRL, 32'h00000001);
      meas(0, 37, 151, 605);
      wr(IDX_UPPER, 32'h00000009);
      wr(IDX_MID, 32'h00000000);
      `CHK(p_lvl, 1'b1)
      meas(1, 16, 67, 269);
      meas(1, 16, 67, 269);
   endtask
   task automatic t_irq();
      logic [31:0] d;
      int n;
      wr(IDX_MASK, 32'h00000004);
      wr(IDX_CTRL, 32'h00000003);
      for (n = 0; n < 1400 && irq !== 1'b1; n++) @(posedge aclk);
      if (n == 1400) tmo();
      `CHK(irq, 1'b1)
      `CHK(irq_vector, 12'h008)
      rd(IDX_STATUS, d);
      `CHK(d[2], 1'b1)
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(IDX_MASK, 32'h00000000);
      repeat (1300) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(IDX_STATUS, d);
      `CHK(d[2], 1'b1)
   endtask
   task automatic t_halt();
      logic [31:0] d;
      @(posedge aclk);
      halt_req <= 1;
      @(posedge aclk);
      halt_req <= 0;
      repeat (3) @(posedge aclk);
      `CHK({speaker_out_positive_oe, speaker_out_negative_oe}, 2'b00)
      rd(IDX_CTRL, d);
      `CHK(d[0], 1'b0)
      wake_req <= 1;
      @(posedge aclk);
      wake_req <= 0;
      repeat (3) @(posedge aclk);
      `CHK({speaker_out_positive_oe, speaker_out_negative_oe}, 2'b11)
      `CHK({speaker_out_positive_o, speaker_out_negative_o}, 2'b00)
   endtask

   // ------------------------------------------------------------------
   // Main sequence: reset for four cycles, then the scenarios in turn.
   // ------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_reset_map();
      t_drive();
      t_pwm();
      t_irq();
      t_halt();
      print_verdict();
   end
endmodule
